// ==== core/lzw_strip_codec_defines.vh ====
// Code values, table limits and width steps of the strip codec
`ifndef LZW_STRIP_CODEC_DEFINES_VH
`define LZW_STRIP_CODEC_DEFINES_VH
`define LZW_CLEAR_CODE   12'h100
`define LZW_EOS_CODE     12'h101
`define LZW_FIRST_CODE   12'h102
`define LZW_FULL_ENTRY   12'hFFE
`define LZW_LAST_SLOT    12'hFFF
`define LZW_STEP_10      13'h0200
`define LZW_STEP_11      13'h0400
`define LZW_STEP_12      13'h0800
`define LZW_MIN_WIDTH    5'h09
`define LZW_MAX_WIDTH    5'h0C
`define LZW_FIFO_DEPTH   16
`endif

// ==== core/lzw_byte_fifo.v ====
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module lzw_byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             core_clk,
	input  wire             rst_b,
	input  wire             ce,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr;
	reg [AW:0]      rd_ptr;
	wire            empty;
	wire            full;
	wire            push;
	wire            pop;

	assign empty     = (wr_ptr == rd_ptr);
	assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
	assign in_ready  = ce && !full;
	assign out_valid = ce && !empty;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// ==== core/lzw_strip_codec.v ====
// LZW strip encoder and decoder with MSB-first byte packing
//
// Notes on behaviour
// - Codes 0 to 255 stand for their own single byte after every table reset.
// - Code 256 is the clear code and never names a string.
// - Code 257 is the end-of-stream code closing every strip.
// - The first added string gets code 258, then successive codes.
// - Extend the prefix on a hit, else emit it, add prefix+K, restart at K.
// - Codes are 9 bits wide after every table reset.
// - Widen to 10, 11, 12 bits after adding entries 511, 1023, 2047.
// - Never more than 12 bits, so at most 4096 table entries.
// - Every emitted data code, the final one too, advances the width decision.
// - Once entry 4094 is used, emit a 12-bit clear and restart at 9 bits.
// - The pending prefix byte survives the full-table clear; sent after it.
// - Each compressed strip opens with a clear and ends with end-of-stream.
// - Each compressed strip starts on a byte boundary; the tail is zero-padded.
// - Codes are packed most significant bit first, one byte at a time.
// - Decoder runs to end-of-stream; after a clear the next code is literal.
// - Known code: output it, add previous plus its first byte; else the special case.
// - Decoder reads 9 bits, widens after storing entries 510, 1022, 2046.
// - The strip is coded as its plain byte sequence, whatever the layout.
// - Decoder follows strings by code directly; encoder uses a hashed table.
// - Each strip starts from a fresh table.
// - Input symbols are whole bytes of value 0 to 255.
`timescale 1ns/100ps
`include "lzw_strip_codec_defines.vh"
module lzw_strip_codec #(
	parameter FIFO_DEPTH = `LZW_FIFO_DEPTH,
	parameter FIFO_AW    = 4
) (
	input  wire       core_clk,
	input  wire       rst_b,
	input  wire       ce,
	input  wire [7:0] raw_data,
	input  wire       raw_valid,
	input  wire       raw_last,
	output wire       raw_ready,
	output wire [7:0] enc_data,
	output wire       enc_valid,
	output wire       enc_last,
	input  wire       enc_ready,
	input  wire [7:0] cmp_data,
	input  wire       cmp_valid,
	output wire       cmp_ready,
	output wire [7:0] dec_data,
	output wire       dec_valid,
	input  wire       dec_ready,
	output reg        dec_strip_end
);
	localparam E_IDLE  = 3'h0;
	localparam E_CLEAR = 3'h1;
	localparam E_SWEEP = 3'h2;
	localparam E_WAIT  = 3'h3;
	localparam E_PROBE = 3'h4;
	localparam E_FIN   = 3'h5;
	localparam E_FLUSH = 3'h6;
	localparam D_READ  = 2'h0;
	localparam D_CODE  = 2'h1;
	localparam D_WALK  = 2'h2;
	localparam D_POP   = 2'h3;

	function [4:0] code_width;
		input [12:0] v;
		begin
			if (v >= `LZW_STEP_12)
				code_width = `LZW_MAX_WIDTH;
			else if (v >= `LZW_STEP_11)
				code_width = 5'h0B;
			else if (v >= `LZW_STEP_10)
				code_width = 5'h0A;
			else
				code_width = `LZW_MIN_WIDTH;
		end
	endfunction

	// Encoder hash table: key is prefix code and next byte
	reg  [19:0] enc_key  [0:4095];
	reg  [11:0] enc_code [0:4095];
	reg         enc_used [0:4095];
	reg  [2:0]  est;
	reg  [11:0] next_code;
	reg  [11:0] prefix;
	reg         have_pre;
	reg  [7:0]  k;
	reg         last_in;
	reg         enc_fin;
	reg  [11:0] slot;
	reg  [19:0] acc;
	reg  [4:0]  n;
	wire [4:0]  ew;
	wire        room;
	wire        hit;
	wire        miss;
	wire        pk_ready;
	wire        pk_valid;
	wire [19:0] pk_shift;

	assign ew        = code_width({1'b0, next_code});
	assign room      = (n < 5'h08);
	assign hit       = enc_used[slot] && (enc_key[slot] == {prefix, k});
	assign miss      = !enc_used[slot];
	assign raw_ready = ce && (est == E_WAIT);
	assign pk_valid  = ce && (n >= 5'h08);
	assign pk_shift  = acc >> (n - 5'h08);

	always @(posedge core_clk)
	begin
		if (ce && est == E_SWEEP)
			enc_used[slot] <= 1'b0;
		else if (ce && est == E_PROBE && miss && room)
		begin
			enc_used[slot] <= 1'b1;
			enc_key[slot]  <= {prefix, k};
			enc_code[slot] <= next_code;
		end
	end

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			est       <= E_IDLE;
			next_code <= `LZW_FIRST_CODE;
			prefix    <= 12'h000;
			have_pre  <= 1'b0;
			k         <= 8'h00;
			last_in   <= 1'b0;
			enc_fin   <= 1'b0;
			slot      <= 12'h000;
			acc       <= 20'h00000;
			n         <= 5'h00;
		end
		else if (ce)
		begin
			if (pk_valid && pk_ready)
				n <= n - 5'h08;
			case (est)
			E_IDLE:
				if (raw_valid)
				begin
					next_code <= `LZW_FIRST_CODE;
					have_pre  <= 1'b0;
					last_in   <= 1'b0;
					est       <= E_CLEAR;
				end
			E_CLEAR:
				if (room)
				begin
					acc  <= (acc << ew) | {8'h00, `LZW_CLEAR_CODE};
					n    <= n + ew;
					slot <= 12'h000;
					est  <= E_SWEEP;
				end
			E_SWEEP:
			begin
				slot <= slot + 12'h001;
				if (slot == `LZW_LAST_SLOT)
				begin
					next_code <= `LZW_FIRST_CODE;
					est       <= last_in ? E_FIN : E_WAIT;
				end
			end
			E_WAIT:
				if (raw_valid)
				begin
					k       <= raw_data;
					last_in <= raw_last;
					if (!have_pre)
					begin
						prefix   <= {4'h0, raw_data};
						have_pre <= 1'b1;
						est      <= raw_last ? E_FIN : E_WAIT;
					end
					else
					begin
						slot <= prefix ^ {raw_data, 4'h0};
						est  <= E_PROBE;
					end
				end
			E_PROBE:
				if (hit)
				begin
					prefix <= enc_code[slot];
					est    <= last_in ? E_FIN : E_WAIT;
				end
				else if (!miss)
					slot <= slot + 12'h001;
				else if (room)
				begin
					acc       <= (acc << ew) | {8'h00, prefix};
					n         <= n + ew;
					next_code <= next_code + 12'h001;
					prefix    <= {4'h0, k};
					if (next_code == `LZW_FULL_ENTRY)
						est <= E_CLEAR;
					else
						est <= last_in ? E_FIN : E_WAIT;
				end
			E_FIN:
				if (room)
				begin
					if (have_pre)
					begin
						acc       <= (acc << ew) | {8'h00, prefix};
						n         <= n + ew;
						have_pre  <= 1'b0;
						next_code <= next_code + 12'h001;
					end
					else
					begin
						acc     <= (acc << ew) | {8'h00, `LZW_EOS_CODE};
						n       <= n + ew;
						enc_fin <= 1'b1;
						est     <= E_FLUSH;
					end
				end
			E_FLUSH:
				if (n == 5'h00)
				begin
					enc_fin <= 1'b0;
					est     <= E_IDLE;
				end
				else if (room)
				begin
					acc <= acc << (5'h08 - n);
					n   <= 5'h08;
				end
			default:
				est <= E_IDLE;
			endcase
		end
	end

	lzw_byte_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) enc_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.ce        (ce),
		.in_data   ({enc_fin && (n == 5'h08), pk_shift[7:0]}),
		.in_valid  (pk_valid),
		.in_ready  (pk_ready),
		.out_data  ({enc_last, enc_data}),
		.out_valid (enc_valid),
		.out_ready (enc_ready)
	);

	// Decoder string table and reversal stack
	reg  [11:0] dec_pre   [0:4095];
	reg  [7:0]  dec_chr   [0:4095];
	reg  [7:0]  dec_first [0:4095];
	reg  [7:0]  stack     [0:4095];
	reg  [1:0]  dst;
	reg  [19:0] dacc;
	reg  [4:0]  dn;
	reg  [11:0] next_d;
	reg  [11:0] prev;
	reg         prev_ok;
	reg  [11:0] code;
	reg  [11:0] cur;
	reg  [12:0] sp;
	wire [4:0]  dw;
	wire [19:0] dshift;
	wire [12:0] dmask;
	wire [7:0]  first_code;
	wire [7:0]  first_prev;
	wire [7:0]  cur_chr;
	wire        known;
	wire        add;
	wire        dq_ready;

	assign dw         = code_width({1'b0, next_d} + 13'h0001);
	assign dshift     = dacc >> (dn - dw);
	assign dmask      = (13'h0001 << dw) - 13'h0001;
	assign first_code = (code < 12'h100) ? code[7:0] : dec_first[code];
	assign first_prev = (prev < 12'h100) ? prev[7:0] : dec_first[prev];
	assign cur_chr    = (cur < 12'h100) ? cur[7:0] : dec_chr[cur];
	assign known      = (code < next_d);
	assign add        = ce && (dst == D_CODE) && prev_ok && (code != `LZW_EOS_CODE)
		&& (code != `LZW_CLEAR_CODE) && (next_d != `LZW_LAST_SLOT);
	assign cmp_ready  = ce && (dst == D_READ) && (dn < dw);

	always @(posedge core_clk)
	begin
		if (add)
		begin
			dec_pre[next_d]   <= prev;
			dec_chr[next_d]   <= known ? first_code : first_prev;
			dec_first[next_d] <= first_prev;
		end
		if (ce && dst == D_WALK)
			stack[sp[11:0]] <= cur_chr;
	end

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dst           <= D_READ;
			dacc          <= 20'h00000;
			dn            <= 5'h00;
			next_d        <= `LZW_FIRST_CODE;
			prev          <= 12'h000;
			prev_ok       <= 1'b0;
			code          <= 12'h000;
			cur           <= 12'h000;
			sp            <= 13'h0000;
			dec_strip_end <= 1'b0;
		end
		else if (ce)
		begin
			dec_strip_end <= 1'b0;
			case (dst)
			D_READ:
				if (dn >= dw)
				begin
					code <= dshift[11:0] & dmask[11:0];
					dn   <= dn - dw;
					dst  <= D_CODE;
				end
				else if (cmp_valid)
				begin
					dacc <= {dacc[11:0], cmp_data};
					dn   <= dn + 5'h08;
				end
			D_CODE:
				if (code == `LZW_EOS_CODE)
				begin
					dn            <= 5'h00;
					next_d        <= `LZW_FIRST_CODE;
					prev_ok       <= 1'b0;
					dec_strip_end <= 1'b1;
					dst           <= D_READ;
				end
				else if (code == `LZW_CLEAR_CODE)
				begin
					next_d  <= `LZW_FIRST_CODE;
					prev_ok <= 1'b0;
					dst     <= D_READ;
				end
				else
				begin
					if (add)
						next_d <= next_d + 12'h001;
					prev    <= code;
					prev_ok <= 1'b1;
					cur     <= code;
					sp      <= 13'h0000;
					dst     <= D_WALK;
				end
			D_WALK:
			begin
				sp <= sp + 13'h0001;
				if (cur < 12'h100)
					dst <= D_POP;
				else
					cur <= dec_pre[cur];
			end
			D_POP:
				if (dq_ready)
				begin
					sp <= sp - 13'h0001;
					if (sp == 13'h0001)
						dst <= D_READ;
				end
			default:
				dst <= D_READ;
			endcase
		end
	end

	lzw_byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) dec_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.ce        (ce),
		.in_data   (stack[sp[11:0] - 12'h001]),
		.in_valid  (ce && dst == D_POP),
		.in_ready  (dq_ready),
		.out_data  (dec_data),
		.out_valid (dec_valid),
		.out_ready (dec_ready)
	);
endmodule

// ==== verif/lzw_stream_partner.sv ====
// Byte source and compressed byte sink around the codec
`timescale 1ns/100ps
module lzw_stream_partner (
	input  logic       core_clk,
	output logic [7:0] raw_data,
	output logic       raw_valid,
	output logic       raw_last,
	input  logic       raw_ready,
	input  logic [7:0] enc_data,
	input  logic       enc_valid,
	input  logic       enc_last,
	output logic       enc_ready
);
	logic [7:0] src_q[$];
	logic [7:0] snk_q[$];
	int         n_last;
	logic [1:0] stall;
	initial
	begin
		raw_data = 8'h00;
		raw_valid = 1'b0;
		raw_last = 1'b0;
		enc_ready = 1'b0;
		n_last = 0;
		stall = 2'h0;
	end
	always @(posedge core_clk)
	begin
		if (raw_valid && raw_ready)
			void'(src_q.pop_front());
		raw_valid <= src_q.size() != 0;
		raw_last <= src_q.size() == 1;
		raw_data <= src_q.size() != 0 ? src_q[0] : ~raw_data;
		if (enc_valid && enc_ready)
		begin
			snk_q.push_back(enc_data);
			n_last += enc_last;
		end
		stall <= stall + 2'h1;
		enc_ready <= stall != 2'h3;
	end
endmodule

// ==== verif/lzw_strip_codec_sva.sv ====
// Port assertions for the strip codec
`timescale 1ns/100ps
module lzw_strip_codec_sva (
	input logic       core_clk,
	input logic       rst_b,
	input logic       ce,
	input logic       raw_valid,
	input logic       raw_last,
	input logic       raw_ready,
	input logic [7:0] enc_data,
	input logic       enc_valid,
	input logic       enc_last,
	input logic       enc_ready,
	input logic       cmp_valid,
	input logic       cmp_ready,
	input logic [7:0] dec_data,
	input logic       dec_valid,
	input logic       dec_ready,
	input logic       dec_strip_end
);
	logic        new_strip;
	logic        first_raw;
	logic        raw_seen;
	logic        cmp_seen;
	logic [12:0] wait_cnt;
	wire         enc_end = enc_valid && enc_ready && enc_last;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	always @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			new_strip <= 1'b1;
			first_raw <= 1'b1;
			raw_seen <= 1'b0;
			cmp_seen <= 1'b0;
			wait_cnt <= 13'h0000;
		end
		else
		begin
			new_strip <= enc_end || (new_strip && !(enc_valid && enc_ready));
			first_raw <= enc_end || (first_raw && !(raw_valid && raw_ready));
			raw_seen <= raw_valid || (raw_seen && !enc_end);
			cmp_seen <= (cmp_valid && cmp_ready) || (cmp_seen && !(dec_strip_end && ce));
			wait_cnt <= (raw_valid && raw_ready) ? 13'h0000
				: wait_cnt + {12'h000, raw_valid && ce && !wait_cnt[12]};
		end
	property p_enc_hold;
		enc_valid && !enc_ready ##1 ce |-> enc_valid && $stable(enc_data) && $stable(enc_last);
	endproperty
	a_enc_hold: assert property (p_enc_hold) else $error("enc byte moved early");
	property p_dec_hold;
		dec_valid && !dec_ready ##1 ce |-> dec_valid && $stable(dec_data);
	endproperty
	a_dec_hold: assert property (p_dec_hold) else $error("dec byte moved early");
	property p_open;
		enc_valid && new_strip |-> enc_data == 8'h80;
	endproperty
	a_open: assert property (p_open) else $error("strip not opened by clear");
	property p_quiet;
		first_raw && !raw_seen |-> !enc_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("output before strip input");
	property p_sweep;
		raw_valid && raw_ready && first_raw |-> wait_cnt >= 13'h1000;
	endproperty
	a_sweep: assert property (p_sweep) else $error("first byte taken too early");
	property p_end_pulse;
		dec_strip_end && ce |=> !dec_strip_end;
	endproperty
	a_end_pulse: assert property (p_end_pulse) else $error("strip end too long");
	property p_end_input;
		dec_strip_end |-> cmp_seen;
	endproperty
	a_end_input: assert property (p_end_input) else $error("strip end without input");
	property p_last_follow;
		raw_valid && raw_ready && raw_last |-> ##[1:300] enc_valid && enc_last;
	endproperty
	a_last_follow: assert property (p_last_follow) else $error("no final byte");
endmodule
bind lzw_strip_codec lzw_strip_codec_sva u_sva (.*);

// ==== verif/tb_lzw_strip_codec.sv ====
// Self-checking bench for the strip codec
`timescale 1ns/100ps
module tb_lzw_strip_codec;
	logic       core_clk, rst_b, ce, raw_valid, raw_last, raw_ready, enc_valid, enc_last;
	logic       enc_ready, cmp_valid, cmp_ready, dec_valid, dec_ready, dec_strip_end;
	logic [7:0] raw_data, enc_data, cmp_data, dec_data;
	logic [7:0] in_q[$], exp_q[$], cmp_q[$], got_q[$];
	int         error_cnt, n_compared, n_end, acc, nb, w, cyc;
	lzw_strip_codec DUT (.*);
	lzw_stream_partner u_far (.*);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		if (cmp_valid && cmp_ready)
			void'(cmp_q.pop_front());
		cmp_valid <= cmp_q.size() != 0;
		cmp_data <= cmp_q.size() != 0 ? cmp_q[0] : ~cmp_data;
		if (dec_valid && dec_ready)
			got_q.push_back(dec_data);
		n_end += dec_strip_end && ce;
		cyc <= cyc + 1;
		dec_ready <= cyc % 5 != 4;
		ce <= cyc % 97 != 0;
	end
	task automatic chk(input string s, input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic int wid(input int n);
		return n > 2047 ? 12 : n > 1023 ? 11 : n > 511 ? 10 : 9;
	endfunction
	task automatic put(input int c);
		acc = (acc << w) | c;
		nb += w;
		while (nb >= 8)
		begin
			nb -= 8;
			exp_q.push_back(8'(acc >> nb));
			acc &= (1 << nb) - 1;
		end
	endtask
	task automatic model();
		int d[int];
		int p;
		int nx;
		exp_q.delete();
		acc = 0;
		nb = 0;
		w = 9;
		nx = 258;
		put(256);
		p = in_q[0];
		for (int i = 1; i < in_q.size(); i++)
			if (d.exists(p * 256 + in_q[i]))
				p = d[p * 256 + in_q[i]];
			else
			begin
				put(p);
				d[p * 256 + in_q[i]] = nx;
				nx++;
				p = in_q[i];
				w = wid(nx);
				if (nx == 4095)
				begin
					put(256);
					d.delete();
					nx = 258;
					w = 9;
				end
			end
		put(p);
		w = wid(nx + 1);
		put(257);
		if (nb > 0)
			exp_q.push_back(8'(acc << (8 - nb)));
	endtask
	task automatic run_strip(input string nm);
		int t;
		int e0;
		int l0;
		model();
		e0 = n_end;
		l0 = u_far.n_last;
		got_q.delete();
		u_far.snk_q.delete();
		cmp_q = exp_q;
		u_far.src_q = in_q;
		for (t = 0; t < 90000 && (n_end == e0 || u_far.n_last == l0
			|| got_q.size() < in_q.size()); t++)
			@(negedge core_clk);
		if (t == 90000)
		begin
			error_cnt++;
			stop_test();
		end
		chk("enc_count", 16'(u_far.snk_q.size()), 16'(exp_q.size()));
		foreach (exp_q[i])
			chk("enc_data", u_far.snk_q[i], exp_q[i]);
		chk("dec_count", 16'(got_q.size()), 16'(in_q.size()));
		foreach (in_q[i])
			chk("dec_data", got_q[i], in_q[i]);
		chk("strip_end", 16'(n_end - e0), 16'h0001);
		chk("enc_last", 16'(u_far.n_last - l0), 16'h0001);
		$display("%s done", nm);
	endtask
	task automatic t_example();
		in_q = '{8'h07, 8'h07, 8'h07, 8'h08, 8'h08, 8'h07, 8'h07, 8'h06, 8'h06};
		run_strip("example");
	endtask
	task automatic t_fresh();
		in_q = '{8'h07, 8'h07};
		run_strip("fresh");
	endtask
	task automatic t_single();
		in_q = '{8'h07};
		run_strip("single");
	endtask
	task automatic t_long();
		in_q.delete();
		for (int i = 0; i < 4400; i++)
			in_q.push_back(8'(i * (2 * (i / 256) + 1) + i / 256));
		run_strip("long");
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		rst_b = 1'b0;
		ce = 1'b1;
		cmp_valid = 1'b0;
		cmp_data = 8'h00;
		dec_ready = 1'b0;
		cyc = 0;
		error_cnt = 0;
		n_compared = 0;
		n_end = 0;
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		@(negedge core_clk);
		t_example();
		t_fresh();
		t_single();
		t_long();
		stop_test();
	end
endmodule
